// file: hw/asus_uart.sv
// Serial channel 0 with port-2 pin control and baud generator.
// Assumes a CPU port doing byte or single-bit register writes.
// ----------------------------------------
// Overview of operation
// R1 - Direction bit 0 drives pin, 1 floats
// R2 - Direction resets to ones, top bits read one
// R3 - Software clears txd direction and latch
// R4 - Software sets rxd and clock directions
// R5 - Both enables zero stops all transfers
// R6 - Mode register resets zero, bit-writable
// R7 - Software sets baud then format bits
// R8 - Software enables tx, rx, then writes data
// R9 - Data write starts enabled transmission
// R10 - Transmit and receive run concurrently
// R11 - Baud is source over 2^(n+1)(k+16)
// R12 - External clock pin replaces system clock
// R13 - Enabled directions take pins, others ports
// R14 - Start, 7/8 data LSB first, parity, stops
// R15 - Parity even, odd, zero or none
// R16 - Seven-bit mode drops and clears bit 7
// R17 - Five-bit counter divides by 16 plus k
// R18 - Baud fields: prescaler 6:4, divider 3:0
// R19 - Error mask suppresses receive-done pulse
// R20 - Idle transmit line rests high
// ----------------------------------------
module asus_uart
   import asus_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [15:0] cpu_addr,
   input  wire logic        cpu_wr,
   input  wire logic        cpu_bit,
   input  wire logic [2:0]  cpu_bit_sel,
   input  wire logic [7:0]  cpu_wdata,
   input  wire logic        cpu_rd,
   output logic      [7:0]  cpu_rdata,
   input  wire logic [5:0]  p2_in,
   output logic      [5:0]  p2_out,
   output logic      [5:0]  p2_oe_n,
   output logic             tx_done_irq,
   output logic             rx_done_irq,
   output logic             rx_err_irq
);
   typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2} asus_tx_t;
   typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} asus_rx_t;

   // ----------------------------------------
   // Pin synchronisers and clock source
   // ----------------------------------------
   logic [5:0] pin_s;
   logic       clk_pin_d_r;
   logic [6:0] pre_r;
   logic [6:0] pre_mask;
   logic       src_tick;

   asus_sync #(.WIDTH(6)) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .din   (p2_in),
      .dout  (pin_s)
   );

   logic [7:0] mode_r, mode_nxt;
   logic [6:0] baud_r, baud_nxt;
   logic [5:0] dir_r, dir_nxt;
   logic [5:0] latch_r, latch_nxt;
   logic [7:0] rxb_r, rxb_nxt;
   logic [2:0] err_r, err_nxt;
   logic       full_r, full_nxt;
   logic [7:0] rdata_nxt;
   logic [2:0] prescale_sel;
   logic [3:0] divider_sel;
   logic       txe, rxe, cl7;
   logic [1:0] par_sel;

   assign prescale_sel = baud_r[ASUS_PRE_MSB:ASUS_PRE_LSB]; // [R18]
   // Prohibited divider 15 is clamped so the counter never overruns
   assign divider_sel  = (baud_r[ASUS_DIV_MSB:0] > ASUS_DIV_MAX) ? ASUS_DIV_MAX
                         : baud_r[ASUS_DIV_MSB:0]; // [R18]
   assign txe     = mode_r[ASUS_TXE_BIT] & ~mode_r[ASUS_IRDA_BIT];
   assign rxe     = mode_r[ASUS_RXE_BIT] & ~mode_r[ASUS_IRDA_BIT];
   assign cl7     = ~mode_r[ASUS_CL_BIT];
   assign par_sel = mode_r[ASUS_PS_HI:ASUS_PS_LO];
   assign pre_mask = 7'((8'h01 << prescale_sel) - 8'h01);
   // Prescaler gives fx/2^n, the half-bit phase flop adds the extra factor of two
   assign src_tick = (prescale_sel == 3'h0) ? (pin_s[ASUS_PIN_CLK] & ~clk_pin_d_r) // [R12]
                     : ((pre_r & pre_mask) == pre_mask); // [R11]

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pre_r       <= 7'h00;
         clk_pin_d_r <= 1'b1;
      end
      else
      begin
         pre_r       <= pre_r + 7'h01;
         clk_pin_d_r <= pin_s[ASUS_PIN_CLK];
      end
   end

   // ----------------------------------------
   // Transmitter
   // ----------------------------------------
   asus_tx_t   tx_st_r, tx_st_nxt;
   logic [7:0] tx_sh_r, tx_sh_nxt;
   logic [2:0] tx_cnt_r, tx_cnt_nxt;
   logic       tx_ph_r, tx_ph_nxt;
   logic       txd_r, txd_nxt;
   logic       tx_par_r, tx_par_nxt;
   logic       tx_done_nxt, tx_restart, tx_half, tx_end, tx_go;
   logic [7:0] tx_data;

   asus_bitclk u_txclk (
      .clk       (clk),
      .rst_n     (rst_n),
      .restart   (tx_restart),
      .src_tick  (src_tick),
      .div_k     (divider_sel),
      .half_tick (tx_half)
   );

   assign tx_go   = cpu_wr && !cpu_bit && cpu_addr == ASUS_ADDR_TXDATA;
   assign tx_data = cl7 ? {1'b0, cpu_wdata[6:0]} : cpu_wdata; // [R16]
   assign tx_end  = tx_half & tx_ph_r;

   always_comb
   begin
      tx_st_nxt   = tx_st_r;
      tx_sh_nxt   = tx_sh_r;
      tx_cnt_nxt  = tx_cnt_r;
      tx_ph_nxt   = tx_half ? ~tx_ph_r : tx_ph_r;
      txd_nxt     = txd_r;
      tx_par_nxt  = tx_par_r;
      tx_done_nxt = 1'b0;
      tx_restart  = 1'b0;
      if (!txe)
      begin
         tx_st_nxt = TX_IDLE; // [R5]
         txd_nxt   = 1'b1;
      end
      else
      begin
         case (tx_st_r)
            TX_IDLE:
            begin
               txd_nxt = 1'b1; // [R20]
               if (tx_go) // [R9]
               begin
                  tx_st_nxt  = TX_START;
                  tx_sh_nxt  = tx_data;
                  tx_cnt_nxt = 3'h0;
                  tx_ph_nxt  = 1'b0;
                  tx_restart = 1'b1;
                  txd_nxt    = 1'b0; // [R14]
                  case (par_sel) // [R15]
                     ASUS_PAR_EVEN: tx_par_nxt = ^tx_data;
                     ASUS_PAR_ODD:  tx_par_nxt = ~^tx_data;
                     default:       tx_par_nxt = 1'b0;
                  endcase
               end
            end
            TX_START:
               if (tx_end)
               begin
                  tx_st_nxt = TX_DATA;
                  txd_nxt   = tx_sh_r[0]; // [R14]
               end
            TX_DATA:
               if (tx_end)
               begin
                  tx_sh_nxt  = {1'b0, tx_sh_r[7:1]};
                  tx_cnt_nxt = tx_cnt_r + 3'h1;
                  if (tx_cnt_r == (cl7 ? 3'h6 : 3'h7))
                  begin
                     tx_st_nxt = (par_sel == ASUS_PAR_NONE) ? TX_STOP1 : TX_PAR;
                     txd_nxt   = (par_sel == ASUS_PAR_NONE) ? 1'b1 : tx_par_r;
                  end
                  else
                     txd_nxt = tx_sh_r[1];
               end
            TX_PAR:
               if (tx_end)
               begin
                  tx_st_nxt = TX_STOP1;
                  txd_nxt   = 1'b1;
               end
            TX_STOP1:
               if (tx_end)
               begin
                  tx_st_nxt   = mode_r[ASUS_SL_BIT] ? TX_STOP2 : TX_IDLE;
                  tx_done_nxt = !mode_r[ASUS_SL_BIT];
               end
            TX_STOP2:
               if (tx_end)
               begin
                  tx_st_nxt   = TX_IDLE;
                  tx_done_nxt = 1'b1;
               end
            default:
               tx_st_nxt = TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         tx_st_r     <= TX_IDLE;
         tx_sh_r     <= 8'h00;
         tx_cnt_r    <= 3'h0;
         tx_ph_r     <= 1'b0;
         txd_r       <= 1'b1;
         tx_par_r    <= 1'b0;
         tx_done_irq <= 1'b0;
      end
      else
      begin
         tx_st_r     <= tx_st_nxt;
         tx_sh_r     <= tx_sh_nxt;
         tx_cnt_r    <= tx_cnt_nxt;
         tx_ph_r     <= tx_ph_nxt;
         txd_r       <= txd_nxt;
         tx_par_r    <= tx_par_nxt;
         tx_done_irq <= tx_done_nxt;
      end
   end

   // ----------------------------------------
   // Receiver, independent of the transmitter
   // ----------------------------------------
   asus_rx_t   rx_st_r, rx_st_nxt;
   logic [7:0] rx_sh_r, rx_sh_nxt;
   logic [2:0] rx_cnt_r, rx_cnt_nxt;
   logic       rx_ph_r, rx_ph_nxt;
   logic       rx_pe_r, rx_pe_nxt;
   logic       rx_restart, rx_half, rx_smp, rx_in, rx_cmp;
   logic       rx_done_nxt, rx_err_nxt;

   asus_bitclk u_rxclk (
      .clk       (clk),
      .rst_n     (rst_n),
      .restart   (rx_restart),
      .src_tick  (src_tick),
      .div_k     (divider_sel),
      .half_tick (rx_half)
   );

   assign rx_in  = pin_s[ASUS_PIN_RX];
   assign rx_smp = rx_half & rx_ph_r;

   always_comb
   begin
      rx_st_nxt  = rx_st_r;
      rx_sh_nxt  = rx_sh_r;
      rx_cnt_nxt = rx_cnt_r;
      rx_ph_nxt  = rx_half ? ~rx_ph_r : rx_ph_r;
      rx_pe_nxt  = rx_pe_r;
      rx_restart = 1'b0;
      rx_cmp     = 1'b0;
      // Dropping the enable abandons the frame with no side effects
      if (!rxe)
         rx_st_nxt = RX_IDLE; // [R5]
      else
      begin
         case (rx_st_r) // [R10]
            RX_IDLE:
               if (!rx_in) // [R13]
               begin
                  rx_st_nxt  = RX_START;
                  rx_restart = 1'b1;
                  rx_ph_nxt  = 1'b1;
                  rx_cnt_nxt = 3'h0;
                  rx_sh_nxt  = 8'h00;
               end
            RX_START:
               if (rx_smp)
                  rx_st_nxt = rx_in ? RX_IDLE : RX_DATA;
            RX_DATA:
               if (rx_smp)
               begin
                  rx_sh_nxt[rx_cnt_r] = rx_in; // [R14]
                  rx_cnt_nxt = rx_cnt_r + 3'h1;
                  if (rx_cnt_r == (cl7 ? 3'h6 : 3'h7))
                     rx_st_nxt = (par_sel == ASUS_PAR_NONE) ? RX_STOP : RX_PAR;
               end
            RX_PAR:
               if (rx_smp)
               begin
                  rx_st_nxt = RX_STOP;
                  case (par_sel) // [R15]
                     ASUS_PAR_EVEN: rx_pe_nxt = ^{rx_sh_r, rx_in};
                     ASUS_PAR_ODD:  rx_pe_nxt = ~^{rx_sh_r, rx_in};
                     default:       rx_pe_nxt = 1'b0;
                  endcase
               end
            RX_STOP:
               if (rx_smp)
               begin
                  rx_st_nxt = RX_IDLE;
                  rx_cmp    = 1'b1;
               end
            default:
               rx_st_nxt = RX_IDLE;
         endcase
      end
      if (rx_st_r == RX_IDLE)
         rx_pe_nxt = 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rx_st_r  <= RX_IDLE;
         rx_sh_r  <= 8'h00;
         rx_cnt_r <= 3'h0;
         rx_ph_r  <= 1'b0;
         rx_pe_r  <= 1'b0;
      end
      else
      begin
         rx_st_r  <= rx_st_nxt;
         rx_sh_r  <= rx_sh_nxt;
         rx_cnt_r <= rx_cnt_nxt;
         rx_ph_r  <= rx_ph_nxt;
         rx_pe_r  <= rx_pe_nxt;
      end
   end

   // ----------------------------------------
   // Register file and pins
   // ----------------------------------------
   function automatic logic [7:0] wr_val(input logic [7:0] old);
      logic [7:0] v;
      v = old;
      if (cpu_bit)
         v[cpu_bit_sel] = cpu_wdata[0];
      else
         v = cpu_wdata;
      return v;
   endfunction

   logic [7:0] port_rd;
   logic       rxb_read;

   always_comb
   begin
      for (int i = 0; i < 6; i++)
         port_rd[i] = dir_r[i] ? pin_s[i] : latch_r[i];
      port_rd[7:6] = 2'h0;
      rxb_read  = cpu_rd && cpu_addr == ASUS_ADDR_RXDATA;
      mode_nxt  = mode_r;
      baud_nxt  = baud_r;
      dir_nxt   = dir_r;
      latch_nxt = latch_r;
      if (cpu_wr)
      begin
         case (cpu_addr)
            ASUS_ADDR_MODE:  mode_nxt = wr_val(mode_r); // [R6]
            ASUS_ADDR_BAUD:  baud_nxt = 7'(wr_val({1'b0, baud_r}));
            ASUS_ADDR_DIR:   dir_nxt = 6'(wr_val({2'h3, dir_r}));
            ASUS_ADDR_LATCH: latch_nxt = 6'(wr_val({2'h0, latch_r}));
            default:         mode_nxt = mode_r;
         endcase
      end
      case (cpu_addr)
         ASUS_ADDR_MODE:    rdata_nxt = mode_r;
         ASUS_ADDR_ERRSTAT: rdata_nxt = {5'h00, err_r};
         ASUS_ADDR_BAUD:    rdata_nxt = {1'b0, baud_r};
         ASUS_ADDR_DIR:     rdata_nxt = {2'h3, dir_r}; // [R2]
         ASUS_ADDR_LATCH:   rdata_nxt = port_rd;
         ASUS_ADDR_RXDATA:  rdata_nxt = rxb_r;
         default:           rdata_nxt = 8'h00;
      endcase
      if (!cpu_rd)
         rdata_nxt = cpu_rdata;
      // A frame finishing on the read cycle wins over the clear
      rxb_nxt     = rxb_r;
      err_nxt     = rxb_read ? 3'h0 : err_r;
      full_nxt    = rxb_read ? 1'b0 : full_r;
      rx_err_nxt  = 1'b0;
      rx_done_nxt = 1'b0;
      if (rx_cmp)
      begin
         rxb_nxt     = cl7 ? {1'b0, rx_sh_r[6:0]} : rx_sh_r; // [R16]
         err_nxt     = {rx_pe_r, ~rx_in, full_r && !rxb_read};
         full_nxt    = 1'b1;
         rx_err_nxt  = |err_nxt;
         rx_done_nxt = !(rx_err_nxt && mode_r[ASUS_ISRM_BIT]); // [R19]
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         mode_r      <= ASUS_MODE_RST; // [R6]
         baud_r      <= ASUS_BAUD_RST[6:0];
         dir_r       <= ASUS_DIR_RST[5:0]; // [R2]
         latch_r     <= ASUS_LATCH_RST[5:0];
         rxb_r       <= 8'h00;
         err_r       <= 3'h0;
         full_r      <= 1'b0;
         cpu_rdata   <= 8'h00;
         rx_done_irq <= 1'b0;
         rx_err_irq  <= 1'b0;
         p2_out      <= ASUS_LATCH_RST[5:0];
         p2_oe_n     <= ASUS_DIR_RST[5:0];
      end
      else
      begin
         mode_r      <= mode_nxt;
         baud_r      <= baud_nxt;
         dir_r       <= dir_nxt;
         latch_r     <= latch_nxt;
         rxb_r       <= rxb_nxt;
         err_r       <= err_nxt;
         full_r      <= full_nxt;
         cpu_rdata   <= rdata_nxt;
         rx_done_irq <= rx_done_nxt;
         rx_err_irq  <= rx_err_nxt;
         p2_oe_n     <= dir_r; // [R1]
         p2_out      <= latch_r;
         p2_out[ASUS_PIN_TX] <= txe ? txd_r : latch_r[ASUS_PIN_TX]; // [R13]
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   dir_reset_a: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
      $rose(rst_n) |-> dir_r == 6'h3F && p2_oe_n == 6'h3F)
      else $error("direction not all inputs after reset");
   mode_reset_a: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
      $rose(rst_n) |-> mode_r == 8'h00)
      else $error("mode register not cleared by reset");
   oe_follow_a: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
      $stable(dir_r) |=> p2_oe_n == $past(dir_r))
      else $error("output enable does not follow direction");
   stop_mode_a: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
      !txe && !rxe |=> tx_st_r == TX_IDLE && rx_st_r == RX_IDLE && !tx_done_irq)
      else $error("transfer running while stopped");
   tx_start_a: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
      tx_go && txe && tx_st_r == TX_IDLE |=> tx_st_r == TX_START ##1 !p2_out[ASUS_PIN_TX])
      else $error("written data did not start a frame");
   tx_idle_a: assert property (@(posedge clk) disable iff (!rst_n) // [R20]
      (txe && tx_st_r == TX_IDLE)[*2] |-> p2_out[ASUS_PIN_TX])
      else $error("idle transmit line not high");
   rx_top_a: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
      rx_cmp && cl7 |=> rxb_r[7] == 1'b0 && full_r)
      else $error("seven-bit character kept its top bit");
   err_mask_a: assert property (@(posedge clk) disable iff (!rst_n) // [R19]
      rx_err_irq && mode_r[ASUS_ISRM_BIT] && $stable(mode_r) |-> !rx_done_irq)
      else $error("masked error raised receive completion");
   half_gap_a: assert property (@(posedge clk) disable iff (!rst_n) // [R17]
      tx_half && prescale_sel == 3'h1 && $stable(baud_r) |=> !tx_half [*8])
      else $error("half-bit tick too early");
endmodule

// file: hw/asus_pkg.sv
// Constants shared by the serial channel and its helper modules.
// Assumes one 20 MHz system clock and a byte-wide CPU register port.
package asus_pkg;
   // ----------------------------------------
   // Register addresses
   // ----------------------------------------
   localparam logic [15:0] ASUS_ADDR_MODE    = 16'h0FA0;
   localparam logic [15:0] ASUS_ADDR_ERRSTAT = 16'hFFA1;
   localparam logic [15:0] ASUS_ADDR_BAUD    = 16'hFFA2;
   localparam logic [15:0] ASUS_ADDR_DIR     = 16'hFF22;
   localparam logic [15:0] ASUS_ADDR_LATCH   = 16'hFF02;
   localparam logic [15:0] ASUS_ADDR_TXDATA  = 16'hFF18;
   localparam logic [15:0] ASUS_ADDR_RXDATA  = 16'hFF19;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] ASUS_MODE_RST  = 8'h00;
   localparam logic [7:0] ASUS_DIR_RST   = 8'hFF;
   localparam logic [7:0] ASUS_BAUD_RST  = 8'h00;
   localparam logic [7:0] ASUS_LATCH_RST = 8'h00;
   // ----------------------------------------
   // Mode register fields
   // ----------------------------------------
   localparam int ASUS_TXE_BIT  = 7;
   localparam int ASUS_RXE_BIT  = 6;
   localparam int ASUS_PS_HI    = 5;
   localparam int ASUS_PS_LO    = 4;
   localparam int ASUS_CL_BIT   = 3;
   localparam int ASUS_SL_BIT   = 2;
   localparam int ASUS_ISRM_BIT = 1;
   localparam int ASUS_IRDA_BIT = 0;
   localparam logic [1:0] ASUS_PAR_NONE = 2'h0;
   localparam logic [1:0] ASUS_PAR_ZERO = 2'h1;
   localparam logic [1:0] ASUS_PAR_ODD  = 2'h2;
   localparam logic [1:0] ASUS_PAR_EVEN = 2'h3;
   // ----------------------------------------
   // Baud register fields and pin positions
   // ----------------------------------------
   localparam int ASUS_PRE_MSB = 6;
   localparam int ASUS_PRE_LSB = 4;
   localparam int ASUS_DIV_MSB = 3;
   localparam logic [3:0] ASUS_DIV_MAX  = 4'hE;
   localparam logic [4:0] ASUS_DIV_BASE = 5'h10;
   localparam int ASUS_PIN_RX  = 3;
   localparam int ASUS_PIN_TX  = 4;
   localparam int ASUS_PIN_CLK = 5;
endpackage

// file: hw/asus_sync.sv
// Two-flop synchroniser for a bus of pin inputs.
// Assumes the inputs are asynchronous to clk.
module asus_sync
   import asus_pkg::*;
#(
   parameter int WIDTH = 6
)(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] dout_nxt;

   // Elaboration-time guard: an empty bus has nothing to synchronise
   if (WIDTH < 1)
   begin : g_width_chk
      $error("asus_sync WIDTH must be positive");
   end

   // Pins idle high so reset loads ones
   always_comb
   begin
      meta_nxt = rst_n ? din : '1;
      dout_nxt = rst_n ? meta_r : '1;
   end

   always_ff @(posedge clk)
   begin
      meta_r <= meta_nxt;
      dout   <= dout_nxt;
   end
endmodule

// file: hw/asus_bitclk.sv
// Baud divider: one half_tick per (16 + k) source ticks.
// Assumes src_tick is a one-cycle pulse on clk.
module asus_bitclk
   import asus_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       restart,
   input  wire logic       src_tick,
   input  wire logic [3:0] div_k,
   output logic            half_tick
);
   logic [4:0] cnt_r;
   logic [4:0] cnt_nxt;
   logic       half_nxt;
   logic [4:0] top;

   always_comb
   begin
      top      = ASUS_DIV_BASE + {1'b0, div_k} - 5'h01;
      cnt_nxt  = cnt_r;
      half_nxt = 1'b0;
      if (restart)
         cnt_nxt = 5'h00;
      else if (src_tick)
      begin
         if (cnt_r == top) // [R17]
         begin
            cnt_nxt  = 5'h00;
            half_nxt = 1'b1;
         end
         else
            cnt_nxt = cnt_r + 5'h01;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cnt_r     <= 5'h00;
         half_tick <= 1'b0;
      end
      else
      begin
         cnt_r     <= cnt_nxt;
         half_tick <= half_nxt;
      end
   end
endmodule

// file: bench/asus_remote.sv
// Remote serial partner model for the link on port-2 pins 3 and 4.
// Assumes the bench passes the bit period in clk cycles.
module asus_remote
   import asus_pkg::*;
(
   input  wire logic clk,
   input  wire logic line_in,
   output logic      line_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // Frame tasks
   // ----------------------------------------
   initial line_out = 1'h1;
   // Two samples per bit, so slow drift in bit length is caught
   task automatic recv(input int bp, input int nb, output logic [11:0] bits, output bit ok);
      int   i;
      logic a;
      bits = 12'hFFF;
      ok = 1'h1;
      // Falling-edge sampling keeps clear of the edge that launches the pin
      for (i = 0; i < 1000 && line_in !== 1'h0; i++)
         @(negedge clk);
      if (line_in !== 1'h0)
         ok = 1'h0;
      for (i = 0; i < nb; i++)
      begin
         repeat (4) @(negedge clk);
         a = line_in;
         repeat (bp - 8) @(negedge clk);
         if (a !== line_in)
            ok = 1'h0;
         repeat (4) @(negedge clk);
         bits[i] = a;
      end
   endtask
   // Line returns to the idle high level after the stops
   task automatic send(input int bp, input int nb, input logic [11:0] bits);
      int i;
      for (i = 0; i < nb; i++)
      begin
         line_out <= bits[i];
         repeat (bp) @(negedge clk);
      end
      line_out <= 1'h1;
   endtask
endmodule

// file: bench/asus_uart_tb.sv
// Bench for the serial channel: registers, port pins and framed traffic.
// Assumes the remote partner model sits on port-2 pins 3 and 4.
module asus_uart_tb
   import asus_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'h0;
   logic        rst_n = 1'h0;
   logic [15:0] cpu_addr = 16'h0;
   logic        cpu_wr = 1'h0;
   logic        cpu_bit = 1'h0;
   logic [2:0]  cpu_bit_sel = 3'h0;
   logic [7:0]  cpu_wdata = 8'h0;
   logic        cpu_rd = 1'h0;
   logic [7:0]  cpu_rdata;
   logic [5:0]  p2_in;
   logic [5:0]  p2_out;
   logic [5:0]  p2_oe_n;
   logic        tx_done_irq;
   logic        rx_done_irq;
   logic        rx_err_irq;
   logic        rem_tx;
   logic        ext_clk = 1'h1;
   logic        seen_tx = 1'h0;
   logic        seen_rx = 1'h0;
   logic        seen_err = 1'h0;
   int          errors = 0;
   int          check_count = 0;
   always #25 clk = ~clk;
   // Free-running baud source on pin 5, a quarter of clk, moving on falling edges
   always #100 ext_clk = ~ext_clk;
   assign p2_in = {ext_clk, 1'h1, rem_tx, 3'h7};
   asus_uart asus_uart_inst (.clk(clk), .rst_n(rst_n), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
      .cpu_bit(cpu_bit), .cpu_bit_sel(cpu_bit_sel), .cpu_wdata(cpu_wdata), .cpu_rd(cpu_rd),
      .cpu_rdata(cpu_rdata), .p2_in(p2_in), .p2_out(p2_out), .p2_oe_n(p2_oe_n),
      .tx_done_irq(tx_done_irq), .rx_done_irq(rx_done_irq), .rx_err_irq(rx_err_irq));
   asus_remote asus_remote_inst (.clk(clk), .line_in(p2_out[ASUS_PIN_TX]), .line_out(rem_tx));
   // Pulses are one cycle wide, so they are latched here
   always @(negedge clk)
   begin
      if (tx_done_irq === 1'h1)
         seen_tx <= 1'h1;
      if (rx_done_irq === 1'h1)
         seen_rx <= 1'h1;
      if (rx_err_irq === 1'h1)
         seen_err <= 1'h1;
   end
   task automatic summarize();
      if (errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b = 1'h0,
                     input logic [2:0] s = 3'h0);
      @(negedge clk);
      cpu_addr = a;
      cpu_wdata = d;
      cpu_bit = b;
      cpu_bit_sel = s;
      cpu_wr = 1'h1;
      @(negedge clk);
      cpu_wr = 1'h0;
   endtask
   task automatic rc(input logic [15:0] a, input logic [7:0] exp, input string what);
      @(negedge clk);
      cpu_addr = a;
      cpu_rd = 1'h1;
      @(negedge clk);
      cpu_rd = 1'h0;
      chk(cpu_rdata, exp, what);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      rc(ASUS_ADDR_DIR, 8'hFF, "dir reset");
      rc(ASUS_ADDR_MODE, 8'h00, "mode reset");
      chk({2'h0, p2_oe_n}, 8'h3F, "oe reset");
   endtask
   // Stopped channel: a data write must leave pin 4 on its latch value
   task automatic t_ports();
      int lo;
      lo = 0;
      wr(ASUS_ADDR_DIR, 8'h2A);
      repeat (2) @(negedge clk);
      chk({2'h0, p2_oe_n}, 8'h2A, "oe follows dir");
      rc(ASUS_ADDR_DIR, 8'hEA, "dir top bits");
      wr(ASUS_ADDR_DIR, 8'hEF);
      wr(ASUS_ADDR_LATCH, 8'h10);
      wr(ASUS_ADDR_TXDATA, 8'h00);
      repeat (300)
      begin
         @(negedge clk);
         if (p2_out[ASUS_PIN_TX] !== 1'h1 || seen_tx !== 1'h0)
            lo++;
      end
      chk({7'h0, lo != 0}, 8'h00, "stopped channel moved pin");
      chk({2'h0, p2_out}, 8'h10, "latch drives pins");
      wr(ASUS_ADDR_LATCH, 8'h00);
   endtask
   task automatic t_frame(input logic [7:0] br, input logic [7:0] fmt, input logic [7:0] d,
                          input logic bad);
      int          bp;
      int          nb;
      int          pi;
      int          i;
      logic [7:0]  v;
      logic [11:0] exp;
      logic [11:0] snd;
      logic [11:0] got;
      bit          ok;
      // Prescaler 0 counts pin-5 rising edges, one per four clk cycles
      bp = (br[6:4] == 3'h0) ? (16 + br[3:0]) * 8 : (16 + br[3:0]) << (br[6:4] + 1);
      v = fmt[3] ? d : {1'h0, d[6:0]};
      exp = 12'hFFF;
      exp[0] = 1'h0;
      for (i = 0; i < (fmt[3] ? 8 : 7); i++)
         exp[1 + i] = d[i];
      nb = fmt[3] ? 9 : 8;
      pi = nb;
      if (fmt[5:4] != 2'h0)
      begin
         exp[nb] = fmt[5] & (fmt[4] ? ^v : ~^v);
         nb++;
      end
      nb = nb + (fmt[2] ? 2 : 1);
      snd = exp;
      snd[pi] = snd[pi] ^ bad;
      wr(ASUS_ADDR_BAUD, br);
      wr(ASUS_ADDR_MODE, fmt);
      wr(ASUS_ADDR_MODE, 8'h01, 1'h1, 3'h7);
      wr(ASUS_ADDR_MODE, 8'h01, 1'h1, 3'h6);
      seen_tx = 1'h0;
      seen_rx = 1'h0;
      seen_err = 1'h0;
      wr(ASUS_ADDR_TXDATA, d);
      fork
         asus_remote_inst.recv(bp, nb, got, ok);
         asus_remote_inst.send(bp, nb, snd);
      join
      for (i = 0; i < 2 * bp && seen_tx !== 1'h1; i++)
         @(negedge clk);
      chk({7'h0, seen_tx}, 8'h01, "tx done");
      chk({7'h0, ok}, 8'h01, "bit timing");
      chk(got[7:0], exp[7:0], "tx low bits");
      chk({4'h0, got[11:8]}, {4'h0, exp[11:8]}, "tx high bits");
      chk({7'h0, p2_out[ASUS_PIN_TX]}, 8'h01, "idle high");
      chk({6'h0, seen_err, seen_rx}, {6'h0, bad, ~(bad & fmt[1])}, "rx pulses");
      rc(ASUS_ADDR_ERRSTAT, {5'h0, bad, 2'h0}, "status");
      rc(ASUS_ADDR_RXDATA, v, "rx data");
      wr(ASUS_ADDR_MODE, 8'h00);
   endtask
   initial
   begin
      repeat (3) @(negedge clk);
      rst_n = 1'h1;
      t_reset();
      t_ports();
      t_frame(8'h10, 8'h38, 8'h55, 1'h0);
      t_frame(8'h23, 8'h24, 8'hB6, 1'h0);
      t_frame(8'h10, 8'h08, 8'h87, 1'h0);
      t_frame(8'h10, 8'h18, 8'h0F, 1'h0);
      t_frame(8'h10, 8'h3A, 8'hA5, 1'h1);
      t_frame(8'h00, 8'h38, 8'hC3, 1'h0);
      summarize();
   end
endmodule
